// file: logic/gpfgh_ports.sv
// gpfgh_ports: data latches, direction registers and pin muxing for the
// seven-pin timer port and the three-pin and two-pin keypad ports, on APB.
// assumes timer channel and keypad logic sit outside and drive the override inputs.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps

module gpfgh_ports
  import gpfgh_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [STRB_W-1:0] pstrb,
  output      logic [DATA_W-1:0] prdata,
  output      logic              pready,
  output      logic              pslverr,
  input  wire gpfgh_pins_type    pinIn,
  output      gpfgh_pins_type    pinOut,
  output      gpfgh_pins_type    pinOe,
  input  wire gpfgh_timer_type   timerIn,
  input  wire logic [KBI_W-1:0]  keypadIrqEnable
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [F_W-1:0]    timerPortData_q;
  logic [G_W-1:0]    keypadPortAData_q;
  logic [H_W-1:0]    keypadPortBData_q;
  logic [F_W-1:0]    timerPortDir_q;
  logic [G_W-1:0]    keypadPortADir_q;
  logic [H_W-1:0]    keypadPortBDir_q;
  logic [DATA_W-1:0] prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  gpfgh_pins_type    pinOut_q;
  gpfgh_pins_type    pinOe_q;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  wire setupPhase   = psel & ~penable;
  wire accessDone   = psel & penable & pready_q;
  wire hitTimerData = (paddr == ADDR_TIMER_DATA);
  wire hitKpaData   = (paddr == ADDR_KPA_DATA);
  wire hitKpbData   = (paddr == ADDR_KPB_DATA);
  wire hitTimerDir  = (paddr == ADDR_TIMER_DIR);
  wire hitKpaDir    = (paddr == ADDR_KPA_DIR);
  wire hitKpbDir    = (paddr == ADDR_KPB_DIR);
  wire addrMapped   = hitTimerData | hitKpaData | hitKpbData |
                      hitTimerDir | hitKpaDir | hitKpbDir;
  // only byte lane 0 carries register bits
  wire writeLow     = accessDone & pwrite & pstrb[0];
  wire wrTimerData  = writeLow & hitTimerData;
  wire wrKpaData    = writeLow & hitKpaData;
  wire wrKpbData    = writeLow & hitKpbData;
  wire wrTimerDir   = writeLow & hitTimerDir;
  wire wrKpaDir     = writeLow & hitKpaDir;
  wire wrKpbDir     = writeLow & hitKpbDir;

  // ----------------------------------------------------------------------
  // pin ownership by timers and keypad
  // ----------------------------------------------------------------------
  logic [TA_N-1:0] timerAOwn;
  logic [TB_N-1:0] timerBOwn;

  genvar ga;
  generate
    for (ga = 0; ga < TA_N; ga++)
    begin : g_ta_own
      assign timerAOwn[ga] = |timerIn.aEls[ga];
    end
  endgenerate

  genvar gb;
  generate
    for (gb = 0; gb < TB_N; gb++)
    begin : g_tb_own
      assign timerBOwn[gb] = |timerIn.bEls[gb];
    end
  endgenerate

  wire [F_W-1:0] timerOwnF = {1'b0, timerBOwn, timerAOwn};
  wire [F_W-1:0] timerOutF = {1'b0, timerIn.bOut, timerIn.aOut};
  wire [F_W-1:0] timerOeF  = {1'b0, timerIn.bOe, timerIn.aOe};
  wire [G_W-1:0] keypadG   = keypadIrqEnable[KBI_G_LSB +: G_W];
  wire [H_W-1:0] keypadH   = keypadIrqEnable[KBI_H_LSB +: H_W];

  // ----------------------------------------------------------------------
  // driver enables and output levels
  // ----------------------------------------------------------------------
  // timer and keypad port drivers
  wire [F_W-1:0] oeF_d  = (timerOwnF & timerOeF) | (~timerOwnF & timerPortDir_q);
  wire [F_W-1:0] valF_d = (timerOwnF & timerOutF) | (~timerOwnF & timerPortData_q);
  wire [G_W-1:0] oeG_d  = keypadPortADir_q & ~keypadG;
  wire [H_W-1:0] oeH_d  = keypadPortBDir_q & ~keypadH;

  // undriven pins show 0 so an unknown latch value reaches pinOut only on a driven pin
  gpfgh_pins_type pinOe_d;
  gpfgh_pins_type pinOut_d;
  assign pinOe_d.f  = oeF_d;
  assign pinOe_d.g  = oeG_d;
  assign pinOe_d.h  = oeH_d;
  assign pinOut_d.f = oeF_d & valF_d;
  assign pinOut_d.g = oeG_d & keypadPortAData_q;
  assign pinOut_d.h = oeH_d & keypadPortBData_q;

  // ----------------------------------------------------------------------
  // read selection
  // ----------------------------------------------------------------------
  // timer and keypad port read sources
  wire [F_W-1:0] readF = (timerPortDir_q & timerPortData_q) | (~timerPortDir_q & pinIn.f);
  wire [G_W-1:0] readG = (keypadPortADir_q & keypadPortAData_q) |
                         (~keypadPortADir_q & pinIn.g);
  wire [H_W-1:0] readH = (keypadPortBDir_q & keypadPortBData_q) |
                         (~keypadPortBDir_q & pinIn.h);

  wire [DATA_W-1:0] prdata_d =
      hitTimerData ? {{(DATA_W-F_W){1'b0}}, readF} :
      hitKpaData   ? {{(DATA_W-G_W){1'b0}}, readG} :
      hitKpbData   ? {{(DATA_W-H_W){1'b0}}, readH} :
      hitTimerDir  ? {{(DATA_W-F_W){1'b0}}, timerPortDir_q} :
      hitKpaDir    ? {{(DATA_W-G_W){1'b0}}, keypadPortADir_q} :
      hitKpbDir    ? {{(DATA_W-H_W){1'b0}}, keypadPortBDir_q} :
                     RDATA_RST;

  // ----------------------------------------------------------------------
  // data latches
  // ----------------------------------------------------------------------
  // latches without reset
  always_ff @(posedge clk)
  begin
    if (wrTimerData) timerPortData_q <= pwdata[F_W-1:0];
    if (wrKpaData) keypadPortAData_q <= pwdata[G_W-1:0];
    if (wrKpbData) keypadPortBData_q <= pwdata[H_W-1:0];
  end

  // ----------------------------------------------------------------------
  // direction registers
  // ----------------------------------------------------------------------
  // direction reset and write
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      timerPortDir_q   <= DIR_F_RST;
      keypadPortADir_q <= DIR_G_RST;
      keypadPortBDir_q <= DIR_H_RST;
    end
    else
    begin
      if (wrTimerDir) timerPortDir_q <= pwdata[F_W-1:0];
      if (wrKpaDir) keypadPortADir_q <= pwdata[G_W-1:0];
      if (wrKpbDir) keypadPortBDir_q <= pwdata[H_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // apb answer and pin flops
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RDATA_RST;
      pinOut_q  <= PINS_RST;
      pinOe_q   <= PINS_RST;
    end
    else
    begin
      pready_q  <= setupPhase;
      pslverr_q <= setupPhase & ~addrMapped;
      prdata_q  <= (setupPhase & ~pwrite) ? prdata_d : RDATA_RST;
      pinOut_q  <= pinOut_d;
      pinOe_q   <= pinOe_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign pinOut  = pinOut_q;
  assign pinOe   = pinOe_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  dir_reset_clear_a: assert property (!$past(resetn) |->
    (timerPortDir_q == DIR_F_RST) && (keypadPortADir_q == DIR_G_RST) &&
    (keypadPortBDir_q == DIR_H_RST) && (pinOe == PINS_RST))
    else $error("direction bits not cleared by reset");

  latch_keep_reset_a: assert property ($rose(resetn) |->
    (timerPortData_q === $past(timerPortData_q, 2)))
    else $error("timer port latch changed across reset");

  dir_drives_pin_a: assert property ((wrKpbDir && (keypadH == 2'h0)) ##1
    (keypadH == 2'h0) |-> ##1 (pinOe.h == $past(pwdata[H_W-1:0], 2)))
    else $error("port B driver enable does not follow direction write");

  timer_read_mux_a: assert property ((setupPhase && !pwrite && hitTimerData) |=>
    (prdata[F_W-1:0] == (($past(timerPortDir_q) & $past(timerPortData_q)) |
                         (~$past(timerPortDir_q) & $past(pinIn.f)))))
    else $error("timer port read returned wrong source");

  kpa_read_mux_a: assert property ((setupPhase && !pwrite && hitKpaData) |=>
    (prdata[G_W-1:0] == (($past(keypadPortADir_q) & $past(keypadPortAData_q)) |
                         (~$past(keypadPortADir_q) & $past(pinIn.g)))))
    else $error("keypad A read returned wrong source");

  // keypad B read of pins when input
  kpb_read_pin_a: assert property ((setupPhase && !pwrite && hitKpbData &&
    (keypadPortBDir_q == 2'h0)) |=> (prdata[H_W-1:0] == $past(pinIn.h)))
    else $error("keypad B input read did not return pins");

  data_write_load_a: assert property (wrTimerData |=>
    (timerPortData_q == $past(pwdata[F_W-1:0])))
    else $error("timer port latch not loaded by write");

  ta_pin_owned_a: assert property (timerAOwn[0] |=>
    (pinOe.f[TA_PIN_LSB] == $past(timerIn.aOe[0])) &&
    (pinOut.f[TA_PIN_LSB] == ($past(timerIn.aOe[0]) & $past(timerIn.aOut[0]))))
    else $error("timer A channel 2 not on its pin");

  tb_pin_owned_a: assert property (timerBOwn[0] |=>
    (pinOe.f[TB_PIN_LSB] == $past(timerIn.bOe[0])))
    else $error("timer B channel 0 not on its pin");

  owned_dir_ignored_a: assert property ((timerAOwn[1] && !timerIn.aOe[1] &&
    timerPortDir_q[TA_PIN_LSB+1]) |=> !pinOe.f[TA_PIN_LSB+1])
    else $error("direction bit drove a timer-owned pin");

  kpa_force_input_a: assert property (keypadG[0] |=> !pinOe.g[0])
    else $error("keypad-enabled port A pin is driven");

  kpb_force_input_a: assert property (keypadH[1] |=> !pinOe.h[1])
    else $error("keypad-enabled port B pin is driven");

  dir_readback_a: assert property ((setupPhase && !pwrite && hitKpaDir) |=>
    (prdata == {{(DATA_W-G_W){1'b0}}, $past(keypadPortADir_q)}))
    else $error("direction register readback mismatch");

  upper_bits_zero_a: assert property ((pready && !pslverr) |->
    (prdata[DATA_W-1:F_W] == '0))
    else $error("unimplemented bits read nonzero");

  apb_ready_time_a: assert property (setupPhase |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

  unmapped_error_a: assert property ((setupPhase && !addrMapped) |=> (pready && pslverr))
    else $error("unmapped address not flagged");

  // ----------------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------------
  cover_dir_then_read: cover property (wrTimerDir ##[1:8] (accessDone && hitTimerData));
  cover_timer_own: cover property (timerAOwn[3] && timerPortDir_q[TA_PIN_LSB+3]);
  cover_keypad_force: cover property (keypadG[2] && keypadPortADir_q[2]);
  cover_unmapped: cover property (pready && pslverr);
  cover_back_to_back: cover property (accessDone ##1 accessDone);

endmodule : gpfgh_ports

// file: logic/gpfgh_pkg.sv
// gpfgh_pkg: constants and carrier types for the three-port parallel I/O block.
// assumes an APB slave with 32-bit data; register byte address is four times the index.
package gpfgh_pkg;

  // ----------------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int IDX_W  = 8;

  // ----------------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_TIMER_DATA = 8'h09;
  localparam logic [IDX_W-1:0] IDX_KPA_DATA   = 8'h0A;
  localparam logic [IDX_W-1:0] IDX_KPB_DATA   = 8'h0B;
  localparam logic [IDX_W-1:0] IDX_TIMER_DIR  = 8'h10;
  localparam logic [IDX_W-1:0] IDX_KPA_DIR    = 8'h11;
  localparam logic [IDX_W-1:0] IDX_KPB_DIR    = 8'h12;

  localparam logic [ADDR_W-1:0] ADDR_TIMER_DATA = {2'h0, IDX_TIMER_DATA, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_KPA_DATA   = {2'h0, IDX_KPA_DATA, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_KPB_DATA   = {2'h0, IDX_KPB_DATA, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_TIMER_DIR  = {2'h0, IDX_TIMER_DIR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_KPA_DIR    = {2'h0, IDX_KPA_DIR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_KPB_DIR    = {2'h0, IDX_KPB_DIR, 2'h0};

  // ----------------------------------------------------------------------
  // port widths and field positions
  // ----------------------------------------------------------------------
  localparam int F_W        = 7;
  localparam int G_W        = 3;
  localparam int H_W        = 2;
  localparam int TA_N       = 4;
  localparam int TB_N       = 2;
  localparam int TA_PIN_LSB = 0;
  localparam int TB_PIN_LSB = 4;
  localparam int KBI_W      = 5;
  localparam int KBI_G_LSB  = 0;
  localparam int KBI_H_LSB  = 3;

  // ----------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------
  localparam logic [F_W-1:0]    DIR_F_RST  = 7'h00;
  localparam logic [G_W-1:0]    DIR_G_RST  = 3'h0;
  localparam logic [H_W-1:0]    DIR_H_RST  = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_RST  = 32'h00000000;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [F_W-1:0] f;
    logic [G_W-1:0] g;
    logic [H_W-1:0] h;
  } gpfgh_pins_type;

  // element 0 of timer A is channel 2; element 0 of timer B is channel 0
  typedef struct packed {
    logic [TA_N-1:0][1:0] aEls;
    logic [TB_N-1:0][1:0] bEls;
    logic [TA_N-1:0]      aOut;
    logic [TA_N-1:0]      aOe;
    logic [TB_N-1:0]      bOut;
    logic [TB_N-1:0]      bOe;
  } gpfgh_timer_type;

  localparam gpfgh_pins_type PINS_RST = '0;

endpackage : gpfgh_pkg

// file: tb/gpfgh_pin_model.sv
// gpfgh_pin_model: external circuit on the port pins.
// assumes the block's pinOut/pinOe; the outside drives every pin it does not see driven.
`timescale 1ns/1ps

module gpfgh_pin_model
  import gpfgh_pkg::*;
(
  input  wire gpfgh_pins_type pinOut,
  input  wire gpfgh_pins_type pinOe,
  input  wire gpfgh_pins_type extLevel,
  output      gpfgh_pins_type pinIn
);
  // ----------------------------------------------------------------------
  // wire level
  // ----------------------------------------------------------------------
  // enabled driver wins
  assign pinIn = gpfgh_pins_type'((pinOe & pinOut) | (~pinOe & extLevel));
endmodule : gpfgh_pin_model

// file: tb/gpfgh_ports_tb.sv
// gpfgh_ports_tb: directed checks of the three-port parallel I/O block.
// assumes an APB slave answering with pready and pins registered one clock after their cause.
`timescale 1ns/1ps

module gpfgh_ports_tb;
  import gpfgh_pkg::*;

  logic              clk;
  logic              resetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [STRB_W-1:0] pstrb;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  gpfgh_pins_type    pinIn;
  gpfgh_pins_type    pinOut;
  gpfgh_pins_type    pinOe;
  gpfgh_pins_type    extLvl;
  gpfgh_timer_type   timerIn;
  logic [KBI_W-1:0]  kbiEn;
  int                errCount;
  int                nTests;

  gpfgh_ports gpfgh_ports_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .timerIn(timerIn), .keypadIrqEnable(kbiEn));

  gpfgh_pin_model gpfgh_pin_model_i (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLvl),
    .pinIn(pinIn));

  // ----------------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic endSim();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : endSim

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    nTests++;
    if (got !== exp)
    begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd,
                     output logic err);
    int   n;
    logic got;
    n = 0;
    got = 1'b0;
    rd = '0;
    err = 1'b0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    while (!got && n < 20)
    begin
      @(posedge clk);
      got = (pready === 1'b1);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!got)
    begin
      errCount++;
      endSim();
    end
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    logic              e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] r;
    logic              e;
    apb(1'b0, a, '0, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h00000000);
  endtask : rdChk

  task automatic pinChk(input logic [11:0] oe, input logic [11:0] out);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(pinOe), 32'(oe));
    chk(32'(pinOut), 32'(out));
  endtask : pinChk

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic scnReset();
    logic [DATA_W-1:0] r;
    logic              e;
    rdChk(ADDR_TIMER_DIR, 32'h00000000);
    rdChk(ADDR_KPA_DIR, 32'h00000000);
    rdChk(ADDR_KPB_DIR, 32'h00000000);
    pinChk(12'h000, 12'h000);
    apb(1'b0, 12'h004, '0, r, e);
    chk({e, r[30:0]}, 32'h80000000);
    pstrb <= 4'hE;
    wr(ADDR_KPA_DIR, 32'h00000007);
    pstrb <= 4'hF;
    rdChk(ADDR_KPA_DIR, 32'h00000000);
  endtask : scnReset

  task automatic scnInputs();
    @(posedge clk);
    extLvl <= gpfgh_pins_type'({7'h55, 3'h5, 2'h2});
    // latches loaded while pins are inputs
    wr(ADDR_TIMER_DATA, 32'hFFFFFF2A);
    wr(ADDR_KPA_DATA, 32'h00000002);
    wr(ADDR_KPB_DATA, 32'h00000001);
    rdChk(ADDR_TIMER_DATA, 32'h00000055);
    rdChk(ADDR_KPA_DATA, 32'h00000005);
    rdChk(ADDR_KPB_DATA, 32'h00000002);
    pinChk(12'h000, 12'h000);
  endtask : scnInputs

  task automatic scnOutputs();
    wr(ADDR_TIMER_DIR, 32'h0000008F);
    wr(ADDR_KPA_DIR, 32'hFFFFFFFF);
    wr(ADDR_KPB_DIR, 32'hFFFFFFFF);
    rdChk(ADDR_TIMER_DIR, 32'h0000000F);
    rdChk(ADDR_KPA_DIR, 32'h00000007);
    rdChk(ADDR_KPB_DIR, 32'h00000003);
    pinChk({7'h0F, 3'h7, 2'h3}, {7'h0A, 3'h2, 2'h1});
    rdChk(ADDR_TIMER_DATA, 32'h0000005A);
    rdChk(ADDR_KPA_DATA, 32'h00000002);
    rdChk(ADDR_KPB_DATA, 32'h00000001);
  endtask : scnOutputs

  task automatic scnTimer();
    gpfgh_timer_type t;
    t = '0;
    t.aEls[0] = 2'h1;
    t.aEls[1] = 2'h2;
    t.bEls[0] = 2'h2;
    t.bEls[1] = 2'h3;
    t.aOut[0] = 1'b1;
    t.bOe[0] = 1'b1;
    t.bOe[1] = 1'b1;
    t.bOut[1] = 1'b1;
    @(posedge clk);
    timerIn <= t;
    pinChk({7'h3C, 3'h7, 2'h3}, {7'h28, 3'h2, 2'h1});
    rdChk(ADDR_TIMER_DATA, 32'h0000006A);
    @(posedge clk);
    timerIn <= '0;
    pinChk({7'h0F, 3'h7, 2'h3}, {7'h0A, 3'h2, 2'h1});
  endtask : scnTimer

  task automatic scnKeypad();
    @(posedge clk);
    kbiEn <= 5'h15;
    pinChk({7'h0F, 3'h2, 2'h1}, {7'h0A, 3'h2, 2'h1});
    @(posedge clk);
    kbiEn <= 5'h0A;
    pinChk({7'h0F, 3'h5, 2'h2}, {7'h0A, 3'h0, 2'h0});
    @(posedge clk);
    kbiEn <= '0;
  endtask : scnKeypad

  task automatic scnMidReset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rdChk(ADDR_KPA_DIR, 32'h00000000);
    pinChk(12'h000, 12'h000);
    wr(ADDR_TIMER_DIR, 32'h0000007F);
    rdChk(ADDR_TIMER_DATA, 32'h0000002A);
    pinChk({7'h7F, 3'h0, 2'h0}, {7'h2A, 3'h0, 2'h0});
  endtask : scnMidReset

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    errCount = 0;
    nTests = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    extLvl = '0;
    timerIn = '0;
    kbiEn = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    scnReset();
    scnInputs();
    scnOutputs();
    scnTimer();
    scnKeypad();
    scnMidReset();
    endSim();
  end
endmodule : gpfgh_ports_tb
